/* rtl/nand_host_pkg.sv */
// constants and types for the nand status/id/reset host controller
// Operation
// - status mode persists; host reissues read command before data reads
// - bits 2..4 read zero; host masks unused status bits
// - identify: command then one zero address, then four id reads
// - host waits recovery time after power-up before any command
// - host holds write protect low during power transitions
package nand_host_pkg;
   localparam logic [7:0]  CMD_STATUS    = 8'h70;
   localparam logic [7:0]  CMD_ID        = 8'h90;
   localparam logic [7:0]  CMD_RESET     = 8'hff;
   localparam logic [7:0]  CMD_READ      = 8'h00;
   localparam logic [7:0]  ID_ADDR       = 8'h00;
   localparam logic [7:0]  STATUS_RESET  = 8'hc0;
   localparam logic [7:0]  STATUS_USED   = 8'he3;
   localparam int          ID_BYTES      = 4;
   localparam int          CLK_MHZ       = 25;
   localparam int          RECOVERY_US   = 10;
   localparam int          RECOVERY_CYC  = RECOVERY_US * CLK_MHZ;
   localparam int          PULSE_CYC     = 2;
   // host register map
   localparam logic [3:0]  REG_CTRL      = 4'h0;
   localparam logic [3:0]  REG_STAT      = 4'h1;
   localparam logic [3:0]  REG_ID0       = 4'h2;
   localparam logic [3:0]  REG_NSTAT     = 4'h3;
   localparam int          CTRL_STATUS   = 0;
   localparam int          CTRL_ID       = 1;
   localparam int          CTRL_RESET    = 2;
   localparam int          CTRL_WP       = 3;
   localparam int          CTRL_READ     = 4;
   typedef enum logic [3:0] {
      ST_RECOVER, ST_IDLE, ST_CMD, ST_ADDR, ST_RD, ST_RDGAP, ST_WAITBSY, ST_WAITRDY
   } state_t;
   typedef enum logic [1:0] {OP_STATUS, OP_ID, OP_RESET, OP_READ} op_t;
endpackage

/* rtl/nand_host.sv */
// host controller issuing status, id and reset sequences to a nand flash
//
// The implementer's own choices: the register addresses and the address-and-strobe port.
`timescale 1ns/10ps
module nand_host #(
   parameter int RECOVERY = nand_host_pkg::RECOVERY_CYC
) (
   input  wire logic                      CLK_I,
   input  wire logic                      RST_I,
   input  wire logic                      CE_I,
   input  wire logic [3:0]                ADDR_I,
   input  wire logic [31:0]               WDATA_I,
   input  wire logic                      WR_I,
   input  wire logic                      RD_I,
   output logic      [31:0]               RDATA_O,
   input  wire logic [7:0]                IO_I,
   output logic      [7:0]                IO_O,
   output logic                           IO_OE_O,
   output logic                           CHIP_SEL_N_O,
   output logic                           CMD_LATCH_O,
   output logic                           ADDR_LATCH_O,
   output logic                           WRITE_STROBE_N_O,
   output logic                           READ_STROBE_N_O,
   output logic                           WRITE_PROT_N_O,
   input  wire logic                      READY_BUSY_I
);
   import nand_host_pkg::*;

   state_t      state_reg, state_next;
   op_t         op_reg;
   logic [15:0] cnt_reg;
   logic [1:0]  idx_reg;
   logic [7:0]  stat_reg;
   logic [31:0] id_reg;
   logic        busy_reg;
   logic        wp_reg;
   logic [7:0]  cmd_byte;
   logic [31:0] rdata_next;
   op_t         op_new;
   op_t         op_cur;

   wire start  = WR_I && ADDR_I == REG_CTRL && state_reg == ST_IDLE;
   wire ctl_wp = WR_I && ADDR_I == REG_CTRL;
   wire pulse_done = cnt_reg == 16'(PULSE_CYC - 1);
   wire stat_sel = ADDR_I == REG_STAT;
   wire id_sel   = ADDR_I == REG_ID0;
   wire nst_sel  = ADDR_I == REG_NSTAT;
   wire ctl_sel  = ADDR_I == REG_CTRL;
   wire latch_entry = (state_next == ST_CMD || state_next == ST_ADDR) && state_next != state_reg;

   // decoded at the start edge so the very first byte on the bus is already the new command
   assign op_new = WDATA_I[CTRL_RESET]  ? OP_RESET  :
                   WDATA_I[CTRL_ID]     ? OP_ID     :
                   WDATA_I[CTRL_STATUS] ? OP_STATUS : OP_READ;
   assign op_cur = start ? op_new : op_reg;

   always_comb begin
      case (op_cur)
         OP_STATUS: cmd_byte = CMD_STATUS;
         OP_ID:     cmd_byte = CMD_ID;
         OP_RESET:  cmd_byte = CMD_RESET;
         default:   cmd_byte = CMD_READ;
      endcase
   end

   // masked status so unused bits never reach software
   wire [7:0] stat_masked = stat_reg & STATUS_USED;

   always_comb begin
      if (ctl_sel) begin
         rdata_next = {28'h0000000, 1'b0, busy_reg, wp_reg, state_reg == ST_IDLE};
      end else if (stat_sel) begin
         rdata_next = {24'h000000, stat_masked};
      end else if (id_sel) begin
         rdata_next = id_reg;
      end else if (nst_sel) begin
         rdata_next = {29'h0, READY_BUSY_I, 1'b0, stat_masked[6]};
      end else begin
         rdata_next = 32'h00000000;
      end
   end

   always_comb begin
      state_next = state_reg;
      case (state_reg)
         ST_RECOVER: if (cnt_reg == 16'(RECOVERY - 1)) state_next = ST_IDLE;
         ST_IDLE:    if (start) state_next = ST_CMD;
         ST_CMD:     if (pulse_done) begin
            if (op_reg == OP_ID) state_next = ST_ADDR;
            else if (op_reg == OP_STATUS) state_next = ST_RD;
            else state_next = ST_WAITBSY;
         end
         ST_ADDR:    if (pulse_done) state_next = ST_RD;
         ST_RD:      if (pulse_done) state_next = ST_RDGAP;
         ST_RDGAP:   if (pulse_done) begin
            if (op_reg == OP_ID && idx_reg != 2'(ID_BYTES - 1)) state_next = ST_RD;
            else state_next = ST_IDLE;
         end
         ST_WAITBSY: if (pulse_done) state_next = ST_WAITRDY;
         ST_WAITRDY: if (READY_BUSY_I) state_next = ST_IDLE;
         default:    state_next = ST_IDLE;
      endcase
   end

   always_ff @(posedge CLK_I) begin
      if (RST_I) begin
         state_reg <= ST_RECOVER;
         op_reg    <= OP_STATUS;
         cnt_reg   <= 16'h0000;
         idx_reg   <= 2'h0;
         stat_reg  <= STATUS_RESET;
         id_reg    <= 32'h00000000;
         busy_reg  <= 1'b0;
         wp_reg    <= 1'b0;
         RDATA_O   <= 32'h00000000;
      end else if (CE_I) begin
         state_reg <= state_next;
         RDATA_O   <= RD_I ? rdata_next : 32'h00000000;
         // write protect held low until software releases it
         if (ctl_wp) wp_reg <= WDATA_I[CTRL_WP];
         cnt_reg <= (state_next != state_reg) ? 16'h0000 : cnt_reg + 16'h0001;
         if (start) begin
            busy_reg <= 1'b1;
            idx_reg  <= 2'h0;
            op_reg   <= op_new;
         end
         if (state_reg == ST_RD && pulse_done) begin
            if (op_reg == OP_STATUS) stat_reg <= IO_I;
            else id_reg <= {IO_I, id_reg[31:8]};
         end
         if (state_reg == ST_RDGAP && pulse_done) idx_reg <= idx_reg + 2'h1;
         if (state_next == ST_IDLE) busy_reg <= 1'b0;
      end
   end

   // pins come from flops so no glitches reach the flash
   always_ff @(posedge CLK_I) begin
      if (RST_I) begin
         IO_O             <= 8'h00;
         IO_OE_O          <= 1'b0;
         CHIP_SEL_N_O     <= 1'b1;
         CMD_LATCH_O      <= 1'b0;
         ADDR_LATCH_O     <= 1'b0;
         WRITE_STROBE_N_O <= 1'b1;
         READ_STROBE_N_O  <= 1'b1;
         WRITE_PROT_N_O   <= 1'b0;
      end else if (CE_I) begin
         WRITE_PROT_N_O   <= wp_reg;
         CHIP_SEL_N_O     <= state_next == ST_IDLE || state_next == ST_RECOVER || state_next == ST_WAITRDY;
         CMD_LATCH_O      <= state_next == ST_CMD;
         ADDR_LATCH_O     <= state_next == ST_ADDR;
         IO_OE_O          <= state_next == ST_CMD || state_next == ST_ADDR;
         IO_O             <= state_next == ST_ADDR ? ID_ADDR : cmd_byte;
         // low for the first cycle only: the rise in the second cycle latches steady data
         WRITE_STROBE_N_O <= !latch_entry;
         READ_STROBE_N_O  <= state_next != ST_RD;
      end
   end

   // protocol checks on the pins and registers the controller drives

   // nothing is selected while the flash is still recovering from power-up
   property p_recover;
      @(posedge CLK_I) disable iff (RST_I)
         state_reg == ST_RECOVER |-> CHIP_SEL_N_O && !CMD_LATCH_O && !ADDR_LATCH_O;
   endproperty
   a_recover: assert property (p_recover) else $error("chip select during recovery");

   // a reset or read may only end once the shared ready line has been released
   property p_rb_wait;
      @(posedge CLK_I) disable iff (RST_I)
         state_reg == ST_WAITRDY && !READY_BUSY_I && CE_I |=> state_reg == ST_WAITRDY;
   endproperty
   a_rb_wait: assert property (p_rb_wait) else $error("left busy wait early");

   // identify is always followed by its single address cycle
   sequence s_cmd;
      state_reg == ST_CMD && op_reg == OP_ID && pulse_done && CE_I;
   endsequence
   property p_id_addr;
      @(posedge CLK_I) disable iff (RST_I)
         s_cmd |=> state_reg == ST_ADDR;
   endproperty
   a_id_addr: assert property (p_id_addr) else $error("id without address");

   // unused status bits never reach software
   property p_mask;
      @(posedge CLK_I) disable iff (RST_I)
         RD_I && stat_sel && CE_I |=> RDATA_O[4:2] == 3'h0;
   endproperty
   a_mask: assert property (p_mask) else $error("unused status bits visible");

   // the flash latches on the rising strobe, so latch enable and data must not move across it
   sequence s_we_low;
      !WRITE_STROBE_N_O && CE_I;
   endsequence
   sequence s_we_rise;
      WRITE_STROBE_N_O && $stable(IO_O) && IO_OE_O && (CMD_LATCH_O || ADDR_LATCH_O);
   endsequence
   property p_we_hold;
      @(posedge CLK_I) disable iff (RST_I)
         s_we_low |=> s_we_rise;
   endproperty
   a_we_hold: assert property (p_we_hold) else $error("write strobe rose with unsteady latch or data");

   // the protect pin follows the software setting one flop later
   property p_wp_pin;
      @(posedge CLK_I) disable iff (RST_I)
         CE_I |=> WRITE_PROT_N_O == $past(wp_reg);
   endproperty
   a_wp_pin: assert property (p_wp_pin) else $error("write protect pin off its setting");

   // never drive the shared bus while the flash may be driving it
   property p_oe_excl;
      @(posedge CLK_I) disable iff (RST_I)
         IO_OE_O |-> READ_STROBE_N_O && !CHIP_SEL_N_O;
   endproperty
   a_oe_excl: assert property (p_oe_excl) else $error("bus driven during a read strobe");

   // a start without command bits sends the plain read command
   property p_read_cmd;
      @(posedge CLK_I) disable iff (RST_I)
         state_reg == ST_CMD && op_reg == OP_READ |-> IO_O == CMD_READ && CMD_LATCH_O;
   endproperty
   a_read_cmd: assert property (p_read_cmd) else $error("read command byte wrong");

   // read data stand only in the cycle after the read strobe
   property p_rdata_idle;
      @(posedge CLK_I) disable iff (RST_I)
         !RD_I && CE_I |=> RDATA_O == 32'h00000000;
   endproperty
   a_rdata_idle: assert property (p_rdata_idle) else $error("read data outside the read cycle");
endmodule

/* test/nand_dev.sv */
// behavioural flash device answering status, id and reset sequences
`timescale 1ns/10ps
module nand_dev #(
   parameter logic [31:0] ID_CODE = 32'h44332211, // arbitrary id bytes
   parameter int          T_RST   = 2000
) (
   input  wire logic       cs_n_i,
   input  wire logic       cle_i,
   input  wire logic       ale_i,
   input  wire logic       we_n_i,
   input  wire logic       re_n_i,
   input  wire logic       wp_n_i,
   input  wire logic [7:0] io_i,
   output wire       [7:0] io_o,
   output wire             rb_o
);
   logic [7:0] cmd_reg  = 8'h00;
   logic [1:0] idx_reg  = 2'h0;
   logic       busy_reg = 1'b0;
   logic [7:0] last_reg = 8'h00;
   wire  [7:0] stat = {wp_n_i, ~busy_reg, ~busy_reg, 5'h00};
   wire  [7:0] dout = (cmd_reg == 8'h70) ? stat : (cmd_reg == 8'h90) ? ID_CODE[idx_reg*8 +: 8] : 8'h5a;
   // released bus shows the inverse so a stale sample cannot pass
   assign io_o = (!cs_n_i && !re_n_i) ? dout : ~last_reg;
   assign rb_o = busy_reg ? 1'b0 : 1'bz;
   always @(posedge we_n_i) begin
      // while busy only status read and reset are taken
      if (!cs_n_i && cle_i && (!busy_reg || io_i == 8'h70 || io_i == 8'hff)) begin
         cmd_reg <= (io_i == 8'hff) ? 8'h00 : io_i;
         idx_reg <= 2'h0;
         if (io_i == 8'hff) begin
            busy_reg <= 1'b1;
            busy_reg <= #(T_RST) 1'b0;
         end
      end else if (!cs_n_i && ale_i) begin
         idx_reg <= 2'h0;
      end
   end
   always @(posedge re_n_i) begin
      last_reg <= dout;
      if (cmd_reg == 8'h90) idx_reg <= idx_reg + 2'h1;
   end
endmodule

/* test/test_nand_host.sv */
// self-checking bench for the nand host controller
`timescale 1ns/10ps
module test_nand_host;
   import nand_host_pkg::*;
   logic        clk = 1'b0, rst = 1'b1, wstb = 1'b0, rstb = 1'b0, rb_low = 1'b0;
   logic        ce = 1'b1;
   localparam logic [31:0] ID_EXP = 32'h44332211; // arbitrary id bytes
   logic [3:0]  addr = 4'h0;
   logic [31:0] wdata = 32'h0;
   wire  [31:0] rdata;
   wire  [7:0]  hio, dio;
   wire         oe, cs_n, cle, ale, we_n, re_n, wp_n;
   tri1         rb;
   int          n_fail = 0;
   int          n_checks = 0;
   always #20 clk = ~clk;
   always @(negedge rb) rb_low = 1'b1;
   nand_host #(.RECOVERY(5)) nand_host_i(.CLK_I(clk), .RST_I(rst), .CE_I(ce), .ADDR_I(addr), .WDATA_I(wdata),
      .WR_I(wstb), .RD_I(rstb), .RDATA_O(rdata), .IO_I(dio), .IO_O(hio), .IO_OE_O(oe), .CHIP_SEL_N_O(cs_n),
      .CMD_LATCH_O(cle), .ADDR_LATCH_O(ale), .WRITE_STROBE_N_O(we_n), .READ_STROBE_N_O(re_n),
      .WRITE_PROT_N_O(wp_n), .READY_BUSY_I(rb));
   nand_dev #(.ID_CODE(ID_EXP)) nand_dev_i(.cs_n_i(cs_n), .cle_i(cle), .ale_i(ale), .we_n_i(we_n),
      .re_n_i(re_n), .wp_n_i(wp_n), .io_i(hio), .io_o(dio), .rb_o(rb));
   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      n_checks++;
      if (got !== exp) begin
         n_fail++;
         $display("[ERR] %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic bus_wr(input logic [3:0] a, input logic [31:0] d);
      @(posedge clk);
      addr <= a; wdata <= d; wstb <= 1'b1;
      @(posedge clk);
      wstb <= 1'b0;
   endtask
   task automatic bus_rd(input logic [3:0] a, output logic [31:0] d);
      @(posedge clk);
      addr <= a; rstb <= 1'b1;
      @(posedge clk);
      rstb <= 1'b0;
      #1 d = rdata;
   endtask
   task automatic wait_idle(output logic [31:0] d);
      d = 32'h0;
      for (int k = 0; k < 400 && d[0] !== 1'b1; k++) bus_rd(REG_CTRL, d);
   endtask
   // a start is refused unless idle, so wait for idle before and after
   task automatic op(input logic [31:0] c);
      logic [31:0] d;
      wait_idle(d);
      bus_wr(REG_CTRL, c);
      wait_idle(d);
      chk("idle", 32'h1, {31'h0, d[0]});
   endtask
   task automatic wrap_up;
      $display("checks %0d mismatches %0d", n_checks, n_fail);
      if (n_fail == 0 && n_checks > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask
   task automatic t_start;
      logic [31:0] d;
      repeat (5) @(posedge clk);
      chk("reset pins", 32'h4, {29'h0, cs_n, wp_n, oe});
      rst <= 1'b0;
      bus_rd(REG_CTRL, d);
      chk("recovering", 32'h0, {31'h0, d[0]});
      op(32'h0);
      bus_rd(4'hf, d);
      chk("unmapped", 32'h0, d);
      $display("test start done");
   endtask
   // status seen through the host register, unused bits masked
   task automatic t_status(input logic [31:0] c, input logic [31:0] exp);
      logic [31:0] d;
      op(c);
      bus_rd(REG_STAT, d);
      chk("status", exp, d);
      $display("test status done");
   endtask
   task automatic t_id;
      logic [31:0] d;
      op(32'ha);
      bus_rd(REG_ID0, d);
      chk("id", ID_EXP, d);
      $display("test id done");
   endtask
   task automatic t_reset;
      logic [31:0] d;
      rb_low = 1'b0;
      op(32'hc);
      op(32'hc);
      chk("busy seen", 32'h1, {31'h0, rb_low});
      bus_rd(REG_NSTAT, d);
      chk("ready pin", 32'h5, d);
      t_status(32'h9, 32'he0);
      $display("test reset done");
   endtask
   // a start written while the clock enable is low must be lost
   task automatic t_freeze;
      logic [31:0] d;
      @(posedge clk);
      ce <= 1'b0;
      bus_wr(REG_CTRL, 32'h0);
      @(posedge clk);
      ce <= 1'b1;
      bus_rd(REG_CTRL, d);
      chk("frozen ctrl", 32'h3, d);
      chk("frozen wp pin", 32'h1, {31'h0, wp_n});
      $display("test freeze done");
   endtask
   initial begin
      #200000;
      n_fail++;
      wrap_up;
   end
   initial begin
      t_start;
      t_status(32'h1, 32'h60);
      t_status(32'h9, 32'he0);
      t_id;
      t_reset;
      t_freeze;
      wrap_up;
   end
endmodule
